// file: ssb_drive_model.sv
// drive model: ramps speed down while asked to
`timescale 1ns/1ps
module ssb_drive_model
   import ssb_pkg::*;
(
   input wire logic i_clk, // clock
   input wire logic i_ramp, // ramp request
   input wire logic i_hold, // drive too slow
   input wire logic i_brake, // brake engaged
   input wire logic i_own_ramp, // drive ramp in use
   output logic [SPD_W-1:0] o_speed // speed
);
   // full speed when idle; the brake stops the motor within one cycle,
   // inside any time-to-zero; else, unless held, one step a cycle, two on own ramp
   always_ff @(posedge i_clk) begin
      if (!i_ramp) begin
         o_speed <= 16'h0100;
      end else if (i_brake) begin
         o_speed <= 16'h0000;
      end else if (!i_hold && o_speed != 16'h0000) begin
         o_speed <= o_speed - (i_own_ramp ? 16'h0002 : 16'h0001);
      end
   end
endmodule

// file: ssb_pkg.sv
// package of constants and types for the safe stop brake sequencer
package ssb_pkg;
   // timebase: one tick per millisecond at 40 MHz
   localparam int CLK_HZ = 40000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
   localparam int TICK_W = 16;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
   // timer and setting widths, in bits
   localparam int TMR_W = 16;
   localparam int SPD_W = 16;
   localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
   localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
   // sequencer states
   typedef enum logic [2:0] {
      SSB_IDLE,
      SSB_RAMP,
      SSB_EXTRA,
      SSB_BRAKE,
      SSB_DONE
   } ssb_state_t;
endpackage

// file: ssb_sequencer.sv
// controlled stop sequencer with speed-limit brake and torque cutoff
`timescale 1ns/1ps
module ssb_sequencer
   import ssb_pkg::*;
(
   input wire logic I_MCLK, // 40 MHz system clock
   input wire logic I_RST, // sync reset, active high
   input wire logic i_stop_req, // controlled stop request pin
   input wire logic i_ack, // acknowledgement pin
   input wire logic [SPD_W-1:0] i_speed, // measured speed magnitude
   input wire logic i_encoder_mode, // encoder-based completion
   input wire logic [SPD_W-1:0] i_brake_speed_limit, // brake limit
   input wire logic [SPD_W-1:0] i_zero_speed_limit, // zero-speed limit
   input wire logic [TMR_W-1:0] i_stop_to_cutoff_delay, // ticks
   input wire logic [TMR_W-1:0] i_extra_cutoff_delay, // ticks, 0 = none
   input wire logic [TMR_W:0] i_brake_to_cutoff_delay, // signed ticks
   input wire logic [TMR_W-1:0] i_brake_time_to_zero, // ticks
   input wire logic [TMR_W-1:0] i_decel_ramp_profile, // ramp setting
   output logic o_stop_state_indication, // stop active
   output logic o_stop_completed_indication, // motor stopped
   output logic o_cutoff_active_indication, // torque cut off
   output logic o_torque_cutoff, // torque cutoff command
   output logic o_brake_control, // brake engage command
   output logic o_ramp_request, // drive to ramp down
   output logic o_use_drive_ramp, // drive uses its own ramp
   output logic o_ack_allowed // acknowledgement accepted now
);
   ////////////////////////////////////////////////////////////////////////
   // input synchronisers and timebase
   logic req_m_q, req_q, ack_m_q, ack_q;
   logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;

   // pin synchronisers
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         req_m_q <= 1'b0;
         req_q <= 1'b0;
         ack_m_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         req_m_q <= i_stop_req;
         req_q <= req_m_q;
         ack_m_q <= i_ack;
         ack_q <= ack_m_q;
      end
   end

   // common tick divider
   always_comb begin
      tick_d = (tick_cnt_q == TICK_LAST);
      tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
   end

   // tick registers
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // settings captured for the length of a stop
   ssb_state_t state_q, state_d;
   logic enc_q, enc_d;
   logic [SPD_W-1:0] brk_lim_q, brk_lim_d, zero_lim_q, zero_lim_d;
   logic [TMR_W-1:0] ext_len_q, ext_len_d, ttz_len_q, ttz_len_d;
   logic [TMR_W:0] btc_q, btc_d;

   // follow the inputs while idle, freeze once a stop is under way
   // so that an edit in mid-stop cannot shorten a running delay
   always_comb begin
      enc_d = enc_q;
      brk_lim_d = brk_lim_q;
      zero_lim_d = zero_lim_q;
      ext_len_d = ext_len_q;
      ttz_len_d = ttz_len_q;
      btc_d = btc_q;
      if (state_q == SSB_IDLE) begin
         enc_d = i_encoder_mode;
         brk_lim_d = i_brake_speed_limit;
         zero_lim_d = i_zero_speed_limit;
         ext_len_d = i_extra_cutoff_delay;
         ttz_len_d = i_brake_time_to_zero;
         btc_d = i_brake_to_cutoff_delay;
      end
   end

   // settings registers
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         enc_q <= 1'b0;
         brk_lim_q <= '0;
         zero_lim_q <= '0;
         ext_len_q <= TMR_ZERO;
         ttz_len_q <= TMR_ZERO;
         btc_q <= '0;
      end else begin
         enc_q <= enc_d;
         brk_lim_q <= brk_lim_d;
         zero_lim_q <= zero_lim_d;
         ext_len_q <= ext_len_d;
         ttz_len_q <= ttz_len_d;
         btc_q <= btc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timers
   logic stc_load, stc_exp, ext_load, ext_exp;
   logic neg_load, neg_exp, ttz_load, ttz_exp, clr_all;
   logic neg_delay;
   logic [TMR_W-1:0] neg_mag;

   // sign of the brake-to-cutoff delay; the most negative value has no
   // magnitude in the timer width and saturates instead of wrapping to 0
   assign neg_delay = btc_q[TMR_W];
   always_comb begin
      neg_mag = TMR_W'(-btc_q);
      if (neg_delay && btc_q[TMR_W-1:0] == TMR_ZERO) begin
         neg_mag = '1;
      end
   end

   // one down-counter per delay, all on the common tick
   ssb_timer u_stop_to_cutoff (
      .i_clk(I_MCLK), .i_rst(I_RST), .i_load(stc_load), .i_stop(clr_all),
      .i_tick(tick_q), .i_len(i_stop_to_cutoff_delay),
      .o_run(), .o_exp(stc_exp)
   );
   ssb_timer u_extra_delay (
      .i_clk(I_MCLK), .i_rst(I_RST), .i_load(ext_load), .i_stop(clr_all),
      .i_tick(tick_q), .i_len(ext_len_q),
      .o_run(), .o_exp(ext_exp)
   );
   ssb_timer u_brake_lead (
      .i_clk(I_MCLK), .i_rst(I_RST), .i_load(neg_load), .i_stop(clr_all),
      .i_tick(tick_q), .i_len(neg_mag),
      .o_run(), .o_exp(neg_exp)
   );
   ssb_timer u_time_to_zero (
      .i_clk(I_MCLK), .i_rst(I_RST), .i_load(ttz_load), .i_stop(clr_all),
      .i_tick(tick_q), .i_len(ttz_len_q),
      .o_run(), .o_exp(ttz_exp)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   logic stop_ind_q, stop_ind_d, done_q, done_d;
   logic cut_q, cut_d, brake_q, brake_d;
   logic ramp_q, ramp_d, own_ramp_q, own_ramp_d;
   logic ack_ok_q, ack_ok_d;
   logic below_brake_q, below_brake_d, at_zero_q, at_zero_d;
   logic ack_valid;

   // speed compares, registered to keep the wide comparators off the
   // state decode; costs one cycle of reaction
   always_comb begin
      below_brake_d = (i_speed < brk_lim_q);
      at_zero_d = (i_speed <= zero_lim_q);
   end

   // compare registers
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         below_brake_q <= 1'b0;
         at_zero_q <= 1'b0;
      end else begin
         below_brake_q <= below_brake_d;
         at_zero_q <= at_zero_d;
      end
   end

   // acknowledge only once complete with request gone
   assign ack_valid = done_q && !req_q && ack_q;

   // next state and outputs
   always_comb begin
      state_d = state_q;
      stop_ind_d = stop_ind_q;
      done_d = done_q;
      cut_d = cut_q;
      brake_d = brake_q;
      ramp_d = ramp_q;
      own_ramp_d = own_ramp_q;
      stc_load = 1'b0;
      ext_load = 1'b0;
      neg_load = 1'b0;
      ttz_load = 1'b0;
      clr_all = 1'b0;
      case (state_q)
         // wait for a synchronised request
         SSB_IDLE: begin
            if (req_q) begin
               stc_load = 1'b1;
               stop_ind_d = 1'b1;
               ramp_d = 1'b1;
               own_ramp_d = (i_decel_ramp_profile == TMR_ZERO);
               state_d = SSB_RAMP;
            end
         end

         // ramping down, watch the brake speed limit
         SSB_RAMP: begin
            if (stc_exp) begin
               cut_d = 1'b1;
            end
            if (below_brake_q) begin
               ext_load = 1'b1;
               state_d = SSB_EXTRA;
            end
         end

         // optional extra delay, then brake; cutoff too unless the brake-to-cutoff delay is negative
         SSB_EXTRA: begin
            if (stc_exp) begin
               cut_d = 1'b1;
            end
            if (ext_exp) begin
               brake_d = 1'b1;
               ttz_load = 1'b1;
               if (neg_delay) begin
                  neg_load = 1'b1;
               end else begin
                  cut_d = 1'b1;
               end
               state_d = SSB_BRAKE;
            end
         end

         // brake on, wait for the motor to stop
         SSB_BRAKE: begin
            if (neg_exp || stc_exp) begin
               cut_d = 1'b1;
            end
            if (enc_q ? at_zero_q : ttz_exp) begin
               done_d = 1'b1;
               state_d = SSB_DONE;
            end
         end

         // stopped, wait for a valid acknowledgement
         SSB_DONE: begin
            if (neg_exp || stc_exp) begin
               cut_d = 1'b1;
            end
            if (ack_valid) begin
               clr_all = 1'b1;
               stop_ind_d = 1'b0;
               done_d = 1'b0;
               cut_d = 1'b0;
               brake_d = 1'b0;
               ramp_d = 1'b0;
               own_ramp_d = 1'b0;
               state_d = SSB_IDLE;
            end
         end
         default: begin
            state_d = SSB_IDLE;
         end
      endcase
      ack_ok_d = (state_d == SSB_DONE) && !req_q;
   end

   // sequencer registers
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         state_q <= SSB_IDLE;
         stop_ind_q <= 1'b0;
         done_q <= 1'b0;
         cut_q <= 1'b0;
         brake_q <= 1'b0;
         ramp_q <= 1'b0;
         own_ramp_q <= 1'b0;
         ack_ok_q <= 1'b0;
      end else begin
         state_q <= state_d;
         stop_ind_q <= stop_ind_d;
         done_q <= done_d;
         cut_q <= cut_d;
         brake_q <= brake_d;
         ramp_q <= ramp_d;
         own_ramp_q <= own_ramp_d;
         ack_ok_q <= ack_ok_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   assign o_stop_state_indication = stop_ind_q;
   assign o_stop_completed_indication = done_q;
   assign o_cutoff_active_indication = cut_q;
   assign o_torque_cutoff = cut_q;
   assign o_brake_control = brake_q;
   assign o_ramp_request = ramp_q;
   assign o_use_drive_ramp = own_ramp_q;
   assign o_ack_allowed = ack_ok_q;
endmodule

// file: ssb_sequencer_assertions.sv
// assertion checker for the sequencer ports
`timescale 1ns/1ps
module ssb_sequencer_assertions
   import ssb_pkg::*;
(
   input wire logic I_MCLK, // clock
   input wire logic I_RST, // reset
   input wire logic i_stop_req, // request pin
   input wire logic [TMR_W:0] i_brake_to_cutoff_delay, // signed
   input wire logic o_stop_state_indication, // stop
   input wire logic o_stop_completed_indication, // done
   input wire logic o_cutoff_active_indication, // cut shown
   input wire logic o_torque_cutoff, // cut
   input wire logic o_brake_control, // brake
   input wire logic o_ramp_request, // ramp
   input wire logic o_ack_allowed // ack open
);
   // all checks run on the system clock, off during reset
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   AST_CUT_IND: assert property (
      o_cutoff_active_indication == o_torque_cutoff) else $error("cut ind");
   AST_REQ_ANSWER: assert property (
      $rose(i_stop_req) && !o_stop_state_indication |->
      ##[2:4] (o_stop_state_indication && o_ramp_request))
      else $error("no stop state");
   AST_STOP_CLEAR: assert property (
      $fell(o_stop_state_indication) |-> $past(o_ack_allowed) &&
      !o_stop_completed_indication && !o_torque_cutoff && !o_brake_control)
      else $error("bad stop clear");
   AST_ACK_GATE: assert property (
      o_ack_allowed |-> o_stop_completed_indication) else $error("ack early");
   AST_BRAKE_POS: assert property (
      $rose(o_brake_control) && !i_brake_to_cutoff_delay[TMR_W] |->
      o_torque_cutoff) else $error("cut not with brake");
   AST_BRAKE_NEG: assert property (
      $rose(o_brake_control) && i_brake_to_cutoff_delay[TMR_W] &&
      !$past(o_torque_cutoff) |-> !o_torque_cutoff) else $error("cut early");
   AST_IN_STOP: assert property (
      o_torque_cutoff || o_brake_control |-> o_stop_state_indication)
      else $error("act outside stop");
   AST_DONE_HOLD: assert property (
      o_stop_completed_indication && !o_ack_allowed |=>
      o_stop_completed_indication) else $error("done dropped");
endmodule
bind ssb_sequencer ssb_sequencer_assertions u_chk (.I_MCLK, .I_RST,
   .i_stop_req, .i_brake_to_cutoff_delay, .o_stop_state_indication,
   .o_stop_completed_indication, .o_cutoff_active_indication,
   .o_torque_cutoff, .o_brake_control, .o_ramp_request, .o_ack_allowed);

// file: ssb_sequencer_test.sv
// self-checking bench for the stop sequencer
`timescale 1ns/1ps
module ssb_sequencer_test
   import ssb_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic ack = 1'b0;
   logic enc = 1'b0;
   logic hold = 1'b0;
   logic [SPD_W-1:0] spd;
   logic [TMR_W-1:0] stc = 16'hFFFF;
   logic [TMR_W-1:0] ext = 16'h0000;
   logic [TMR_W-1:0] ttz = 16'h0000;
   logic [TMR_W-1:0] prof = 16'h0005;
   logic [TMR_W:0] btc = 17'h00000;
   logic st, cpl, cai, cut, brk, rmp, own, aal;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   ssb_sequencer u_dut (.I_MCLK(clk), .I_RST(rst), .i_stop_req(req),
      .i_ack(ack), .i_speed(spd), .i_encoder_mode(enc),
      .i_brake_speed_limit(16'h0080), .i_zero_speed_limit(16'h0010),
      .i_stop_to_cutoff_delay(stc), .i_extra_cutoff_delay(ext),
      .i_brake_to_cutoff_delay(btc), .i_brake_time_to_zero(ttz),
      .i_decel_ramp_profile(prof), .o_stop_state_indication(st),
      .o_stop_completed_indication(cpl), .o_cutoff_active_indication(cai),
      .o_torque_cutoff(cut), .o_brake_control(brk), .o_ramp_request(rmp),
      .o_use_drive_ramp(own), .o_ack_allowed(aal));
   ssb_drive_model u_drv (.i_clk(clk), .i_ramp(rmp), .i_hold(hold),
      .i_brake(brk), .i_own_ramp(own), .o_speed(spd));
   ////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // compare one bit, report a mismatch
   task check(input logic v, input logic e);
      compares++;
      if (v !== e) begin
         error_cnt++;
         $display("ERROR %0t: mismatch", $time);
      end
   endtask
   task report_and_stop;
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task cw(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one whole stop sequence, request to acknowledgement
   task run_stop(input logic e, h, input logic [TMR_W:0] b,
         input logic [TMR_W-1:0] s, x, t, p);
      enc = e;
      hold = h;
      btc = b;
      stc = s;
      ext = x;
      ttz = t;
      prof = p;
      req = 1'b1;
      cw(5);
      check(st, 1'b1);
      check(own, p == 16'h0000);
      while (!(brk || cut)) @(negedge clk);
      if (h) begin
         check(brk, 1'b0);
         hold = 1'b0;
         while (!brk) @(negedge clk);
      end else begin
         check(spd < 16'h0080, 1'b1);
      end
      check(cai, h || !b[TMR_W]);
      while (!cut) @(negedge clk);
      while (!cpl) @(negedge clk);
      check(spd <= 16'h0010 || !e, 1'b1);
      check(brk && cai, 1'b1);
      check(spd == 16'h0000, 1'b1);
      ack = 1'b1;
      cw(5);
      check(st, 1'b1);
      check(aal, 1'b0);
      ack = 1'b0;
      req = 1'b0;
      cw(5);
      check(aal, 1'b1);
      ack = 1'b1;
      cw(5);
      check(st | cpl | cai | cut | brk | rmp | own | aal, 1'b0);
      ack = 1'b0;
      cw(5);
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   // reset, four stop variants, then a reset in mid-sequence
   initial begin
      cw(8);
      rst = 1'b0;
      run_stop(0, 0, 17'h00000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0005);
      run_stop(0, 0, 17'h1FFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
      run_stop(0, 1, 17'h00003, 16'h0000, 16'h0000, 16'h0000, 16'h0005);
      run_stop(1, 0, 17'h00000, 16'hFFFF, 16'h0001, 16'hFFFF, 16'h0005);
      req = 1'b1;
      cw(5);
      rst = 1'b1;
      cw(8);
      check(st | rmp, 1'b0);
      rst = 1'b0;
      req = 1'b0;
      cw(5);
      report_and_stop;
   end
endmodule

// file: ssb_timer.sv
// down-counting tick timer with load and expiry flag
`timescale 1ns/1ps
module ssb_timer
   import ssb_pkg::*;
(
   input wire logic i_clk, // system clock
   input wire logic i_rst, // sync reset
   input wire logic i_load, // load and start
   input wire logic i_stop, // stop and clear
   input wire logic i_tick, // timebase enable
   input wire logic [TMR_W-1:0] i_len, // length in ticks
   output logic o_run, // counting
   output logic o_exp // expired, level
);
   logic [TMR_W-1:0] cnt_q, cnt_d;
   logic run_q, run_d, exp_q, exp_d;

   // next count and flags
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = exp_q;
      if (i_stop) begin
         cnt_d = TMR_ZERO;
         run_d = 1'b0;
         exp_d = 1'b0;
      end else if (i_load) begin
         cnt_d = i_len;
         run_d = (i_len != TMR_ZERO);
         exp_d = (i_len == TMR_ZERO);
      end else if (run_q && i_tick) begin
         cnt_d = cnt_q - TMR_ONE;
         if (cnt_q == TMR_ONE) begin
            run_d = 1'b0;
            exp_d = 1'b1;
         end
      end
   end

   // registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= TMR_ZERO;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign o_run = run_q;
   assign o_exp = exp_q;
endmodule
